// ===== rtl/async_serial_receiver.sv
// asynchronous serial receiver with two-entry buffer and avalon slave
//
// Function
// - line sampled at sixteen times bit rate; shift once per bit
// - finished 8 or 9 bit character moves at once into two-entry buffer
// - falling edge starts character; start bit checked low at its centre
// - start bit high at centre: drop silently, no error, watch again
// - each bit taken by majority at its centre, one bit time apart
// - stop bit sampled; low marks framing error on that character, high leaves its bit clear
// - after stop bit character is pushed, pending flag rises
// - data register read returns oldest character and removes it
// - polarity bit set inverts the received line
// - pending high when receiver enabled and a character is buffered
// - pending ignores irq enables; irq needs all three enables
// - framing bit kept per character; status shows oldest only
// - framing error does not stop reception; data read advances it
// - framing status cleared by data read or port disable; no irq from it
// - third character with buffer full sets overrun, stops reception
// - overrun cleared by clearing receive enable or port enable
// - nine-bit mode shifts nine bits; ninth status shows oldest msb
// - address detect in nine-bit mode keeps only ninth-bit-set chars
// - reception runs only with rx enable, async mode, port enable
// - port enabled forces transmit pin output, general latch cut off
// - port disable holds the whole port in reset
// - idle flag high while idle, low from start bit to completion
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module async_serial_receiver #(
	parameter logic [15:0] DIV_DEFAULT = async_rx_pkg::DIV_RESET
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic serialInPin,
	input wire logic gpioLatch,
	input wire logic gpioOutEn,
	output logic serialOutPin,
	output logic serialOutOe,
	output logic rxIrq
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	async_rx_pkg::ctrl_t ctrl_ff;
	logic [15:0] div_ff;
	logic waitReq_ff;
	logic [31:0] rdData_ff;
	logic irq_ff;
	logic pinOut_ff;
	logic pinOe_ff;
	logic [15:0] tickCnt_ff;
	logic [3:0] phase_ff;
	logic [1:0] samp_ff;
	logic lineD_ff;
	async_rx_pkg::rx_state_t state_ff;
	logic [3:0] bitCnt_ff;
	logic [8:0] shift_ff;
	logic overrun_ff;
	async_rx_pkg::rx_char_t fifo_ff [2];
	logic rdPtr_ff;
	logic wrPtr_ff;
	logic [1:0] count_ff;
	async_rx_pkg::rx_state_t nxt_state;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire busReq = avs_read | avs_write;
	wire busDone = busReq & ~waitReq_ff;
	wire selCtrl = avs_address == async_rx_pkg::ADDR_CTRL;
	wire selStatus = avs_address == async_rx_pkg::ADDR_STATUS;
	wire selData = avs_address == async_rx_pkg::ADDR_DATA;
	wire selDiv = avs_address == async_rx_pkg::ADDR_DIV;
	wire [31:0] beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire wrCtrl = busDone & avs_write & selCtrl;
	wire wrDiv = busDone & avs_write & selDiv;
	wire [31:0] ctrlWord = {23'h0, ctrl_ff};
	wire [31:0] divWord = {16'h0, div_ff};
	wire [31:0] ctrlMerged = (ctrlWord & ~beMask) | (avs_writedata & beMask);
	wire [31:0] divMerged = (divWord & ~beMask) | (avs_writedata & beMask);
	wire popReq = busDone & avs_read & selData;

	// ------------------------------------------------------------
	// enables and line conditioning
	// ------------------------------------------------------------
	wire portOn = ctrl_ff.port_enable;
	wire nineSel = ctrl_ff.rx_nine_bit_sel;
	wire running = portOn & ctrl_ff.rx_enable & ~ctrl_ff.sync_sel
		& ~overrun_ff;
	wire rxLine = serialInPin ^ ctrl_ff.rx_polarity;
	wire fallEdge = lineD_ff & ~rxLine;

	// ------------------------------------------------------------
	// oversampling tick and bit centre
	// ------------------------------------------------------------
	wire tick = tickCnt_ff >= div_ff;
	wire atCentre = tick & (phase_ff == async_rx_pkg::MID_PHASE);
	wire majority = (samp_ff[1] & samp_ff[0]) | (samp_ff[1] & rxLine)
		| (samp_ff[0] & rxLine);
	wire [3:0] charBits = nineSel ? async_rx_pkg::BITS_NINE
		: async_rx_pkg::BITS_EIGHT;
	wire lastBit = bitCnt_ff == charBits - 4'h1;

	// ------------------------------------------------------------
	// character completion
	// ------------------------------------------------------------
	wire stopTaken = (state_ff == async_rx_pkg::RX_STOP) & atCentre
		& running;
	wire [8:0] charData = nineSel ? shift_ff : {1'b0, shift_ff[8:1]};
	wire addrReject = ctrl_ff.addr_detect_enable & nineSel
		& ~charData[8];
	wire keepChar = stopTaken & ~addrReject;
	wire fifoFull = count_ff == async_rx_pkg::FIFO_DEPTH;
	wire doPop = popReq & (count_ff != 2'h0);
	wire doPush = keepChar & (~fifoFull | doPop);
	wire setOverrun = keepChar & fifoFull & ~doPop;
	wire clrOverrun = ~portOn | ~ctrl_ff.rx_enable;
	async_rx_pkg::rx_char_t newChar;
	assign newChar.framing_error = ~majority;
	assign newChar.data = charData;

	// ------------------------------------------------------------
	// status view
	// ------------------------------------------------------------
	async_rx_pkg::rx_char_t topChar;
	assign topChar = fifo_ff[rdPtr_ff];
	wire hasChar = count_ff != 2'h0;
	wire pending = ctrl_ff.rx_enable & portOn & hasChar;
	wire topFerr = hasChar & topChar.framing_error;
	wire topNinth = hasChar & topChar.data[8];
	wire rxIdle = state_ff == async_rx_pkg::RX_IDLE;
	wire irqNext = pending & ctrl_ff.rx_irq_enable
		& ctrl_ff.peripheral_irq_enable
		& ctrl_ff.global_irq_enable;
	wire [31:0] statusWord = {26'h0, irqNext, rxIdle, topNinth,
		overrun_ff, topFerr, pending};
	wire [31:0] dataWord = {23'h0, topChar.data};
	wire [31:0] readMux = selCtrl ? ctrlWord
		: selStatus ? statusWord
		: selData ? dataWord
		: selDiv ? divWord
		: 32'h0;

	// ------------------------------------------------------------
	// receive state machine
	// ------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			async_rx_pkg::RX_IDLE: begin
				if (fallEdge) begin
					nxt_state = async_rx_pkg::RX_START;
				end
			end
			async_rx_pkg::RX_START: begin
				if (atCentre) begin
					nxt_state = majority ? async_rx_pkg::RX_IDLE
						: async_rx_pkg::RX_DATA;
				end
			end
			async_rx_pkg::RX_DATA: begin
				if (atCentre & lastBit) begin
					nxt_state = async_rx_pkg::RX_STOP;
				end
			end
			async_rx_pkg::RX_STOP: begin
				if (atCentre) begin
					nxt_state = async_rx_pkg::RX_IDLE;
				end
			end
		endcase
		if (!running) begin
			nxt_state = async_rx_pkg::RX_IDLE;
		end
	end

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			waitReq_ff <= 1'b1;
			rdData_ff <= 32'h0;
		end else begin
			waitReq_ff <= ~(busReq & waitReq_ff);
			if (busReq & waitReq_ff) begin
				rdData_ff <= avs_read ? readMux : 32'h0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ctrl_ff <= async_rx_pkg::CTRL_RESET;
			div_ff <= DIV_DEFAULT;
		end else begin
			if (wrCtrl) begin
				ctrl_ff <= ctrlMerged[async_rx_pkg::CTRL_WIDTH-1:0];
			end
			if (wrDiv) begin
				div_ff <= divMerged[15:0];
			end
		end
	end

	// ------------------------------------------------------------
	// pins and interrupt request
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pinOut_ff <= 1'b0;
			pinOe_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			pinOut_ff <= portOn ? 1'b1 : gpioLatch;
			pinOe_ff <= portOn | gpioOutEn;
			irq_ff <= irqNext;
		end
	end

	// ------------------------------------------------------------
	// oversampling counters
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			tickCnt_ff <= 16'h0;
			phase_ff <= 4'h0;
			samp_ff <= 2'h3;
			lineD_ff <= 1'b1;
		end else begin
			lineD_ff <= rxLine;
			if (!running || (rxIdle && fallEdge)) begin
				tickCnt_ff <= 16'h0;
				phase_ff <= 4'h0;
				samp_ff <= 2'h3;
			end else if (tick) begin
				tickCnt_ff <= 16'h0;
				phase_ff <= phase_ff + 4'h1;
				samp_ff <= {samp_ff[0], rxLine};
			end else begin
				tickCnt_ff <= tickCnt_ff + 16'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// shift register and bit counting
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_ff <= async_rx_pkg::RX_IDLE;
			bitCnt_ff <= 4'h0;
			shift_ff <= 9'h0;
		end else begin
			state_ff <= nxt_state;
			if (state_ff == async_rx_pkg::RX_START) begin
				bitCnt_ff <= 4'h0;
			end else if (state_ff == async_rx_pkg::RX_DATA
				&& atCentre) begin
				shift_ff <= {majority, shift_ff[8:1]};
				bitCnt_ff <= bitCnt_ff + 4'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// overrun flag
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			overrun_ff <= 1'b0;
		end else if (clrOverrun) begin
			overrun_ff <= 1'b0;
		end else if (setOverrun) begin
			overrun_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// two-entry character buffer
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rdPtr_ff <= 1'b0;
			wrPtr_ff <= 1'b0;
			count_ff <= 2'h0;
		end else if (!portOn) begin
			rdPtr_ff <= 1'b0;
			wrPtr_ff <= 1'b0;
			count_ff <= 2'h0;
		end else begin
			if (doPush) begin
				wrPtr_ff <= ~wrPtr_ff;
			end
			if (doPop) begin
				rdPtr_ff <= ~rdPtr_ff;
			end
			count_ff <= count_ff + {1'b0, doPush} - {1'b0, doPop};
		end
	end

	for (genvar i = 0; i < 2; i++) begin : g_entry
		always_ff @(posedge clk_sys or posedge reset) begin
			if (reset) begin
				fifo_ff[i] <= '0;
			end else if (!portOn) begin
				fifo_ff[i] <= '0;
			end else if (doPush && wrPtr_ff == 1'(i)) begin
				fifo_ff[i] <= newChar;
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign avs_readdata = rdData_ff;
	assign avs_waitrequest = waitReq_ff;
	assign serialOutPin = pinOut_ff;
	assign serialOutOe = pinOe_ff;
	assign rxIrq = irq_ff;
endmodule

// ===== pkg/async_rx_pkg.sv
// shared constants and types for the asynchronous serial receiver
package async_rx_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_DATA = 4'h8;
	localparam logic [3:0] ADDR_DIV = 4'hc;
	// ------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------
	localparam int CTRL_WIDTH = 9;
	localparam logic [8:0] CTRL_RESET = 9'h000;
	localparam logic [15:0] DIV_RESET = 16'h0043;
	// ------------------------------------------------------------
	// sampling
	// ------------------------------------------------------------
	localparam int OVERSAMPLE = 16;
	localparam logic [3:0] MID_PHASE = 4'(OVERSAMPLE / 2 - 1);
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [3:0] BITS_NINE = 4'h9;
	localparam logic [1:0] FIFO_DEPTH = 2'h2;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic global_irq_enable;
		logic peripheral_irq_enable;
		logic rx_irq_enable;
		logic rx_polarity;
		logic addr_detect_enable;
		logic rx_nine_bit_sel;
		logic sync_sel;
		logic rx_enable;
		logic port_enable;
	} ctrl_t;
	typedef struct packed {
		logic framing_error;
		logic [8:0] data;
	} rx_char_t;
	typedef enum logic [1:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP
	} rx_state_t;
endpackage

// ===== test/async_rx_sva.sv
// assertions for the asynchronous serial receiver
`timescale 1ns/1ps
module async_rx_sva (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic gpioLatch,
	input wire logic gpioOutEn,
	input wire logic serialOutPin,
	input wire logic serialOutOe,
	input wire logic rxIrq
);
	logic [8:0] ctl_ff;
	wire done = !avs_waitrequest;
	wire stRd = avs_read && done && avs_address == async_rx_pkg::ADDR_STATUS;
	wire ctlWr = avs_write && done && avs_address == async_rx_pkg::ADDR_CTRL;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ctl_ff <= async_rx_pkg::CTRL_RESET;
		end else if (ctlWr) begin
			ctl_ff <= avs_writedata[8:0];
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer off");
	AST_PINS_PORT: assert property (
		ctl_ff[0] && $past(ctl_ff[0]) |-> serialOutOe && serialOutPin)
		else $error("pin not forced");
	AST_PINS_GPIO: assert property (
		!$past(reset) && !ctl_ff[0] && !$past(ctl_ff[0]) |->
		serialOutOe == $past(gpioOutEn) && serialOutPin == $past(gpioLatch))
		else $error("pin not general");
	AST_IRQ_EN: assert property (rxIrq |->
		$past(ctl_ff[8:6]) == 3'h7 && $past(ctl_ff[1:0]) == 2'h3)
		else $error("irq without enables");
	AST_PEND_RUN: assert property (
		stRd && avs_readdata[0] |-> ctl_ff[1:0] == 2'h3)
		else $error("pending while stopped");
	AST_IDLE_RUN: assert property (
		stRd && !avs_readdata[4] |-> ctl_ff[1:0] == 2'h3)
		else $error("busy while stopped");
	AST_OVR_CLR: assert property (
		stRd && !ctl_ff[1] |-> !avs_readdata[2]) else $error("overrun kept");
	AST_PORT_RST: assert property (
		stRd && !ctl_ff[0] |-> avs_readdata[2:0] == 3'h0)
		else $error("status kept in port reset");
	COV_PEND: cover property (stRd && avs_readdata[0]);
	COV_OVR: cover property (stRd && avs_readdata[2]);
	COV_IRQ: cover property (rxIrq);
endmodule
bind async_serial_receiver async_rx_sva i_sva (.clk_sys(clk_sys),
	.reset(reset), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.gpioLatch(gpioLatch), .gpioOutEn(gpioOutEn),
	.serialOutPin(serialOutPin), .serialOutOe(serialOutOe), .rxIrq(rxIrq));

// ===== test/serial_tx_model.sv
// remote serial transmitter driving the receive line
`timescale 1ns/1ps
module serial_tx_model #(
	parameter int BIT_CLKS = 16
) (
	input wire logic clk_sys,
	input wire logic invert,
	output logic line
);
	logic lvl_ff = 1'b1;
	assign line = lvl_ff ^ invert;
	// one frame, then one idle bit; a short start makes a false start
	task automatic send(input logic [8:0] d, input logic nine,
		input logic stopBit, input int startLen);
		lvl_ff <= 1'b0;
		repeat (startLen) @(posedge clk_sys);
		if (startLen == BIT_CLKS) begin
			for (int i = 0; i < (nine ? 9 : 8); i++) begin
				lvl_ff <= d[i];
				repeat (BIT_CLKS) @(posedge clk_sys);
			end
			lvl_ff <= stopBit;
			repeat (BIT_CLKS) @(posedge clk_sys);
		end
		lvl_ff <= 1'b1;
		repeat (BIT_CLKS) @(posedge clk_sys);
	endtask
endmodule

// ===== test/testbench.sv
// self-checking bench for the asynchronous serial receiver
`timescale 1ns/1ps
module testbench;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic serialInPin;
	logic gpioLatch = 1'b0;
	logic gpioOutEn = 1'b1;
	logic serialOutPin;
	logic serialOutOe;
	logic rxIrq;
	logic invert = 1'b0;
	logic [31:0] q;
	int bad_count = 0;
	int compares = 0;
	int cycles = 0;
	typedef struct {logic [8:0] c; logic [8:0] d; logic s; logic v;
		logic [31:0] st;} row_t;
	row_t rows [5] = '{'{9'h003, 9'h0a5, 1'b1, 1'b0, 32'h11},
		'{9'h003, 9'h03c, 1'b0, 1'b0, 32'h13}, '{9'h00b, 9'h15a, 1'b1, 1'b0,
		32'h19}, '{9'h023, 9'h081, 1'b1, 1'b1, 32'h11},
		'{9'h1c3, 9'h07e, 1'b1, 1'b0, 32'h31}};
	async_serial_receiver i_dut (.clk_sys(clk_sys), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .serialInPin(serialInPin),
		.gpioLatch(gpioLatch), .gpioOutEn(gpioOutEn),
		.serialOutPin(serialOutPin), .serialOutOe(serialOutOe), .rxIrq(rxIrq));
	serial_tx_model i_tx (.clk_sys(clk_sys), .invert(invert),
		.line(serialInPin));
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wrc(input logic [8:0] c);
		bus(1'b1, async_rx_pkg::ADDR_CTRL, {23'h0, c});
	endtask
	task automatic fresh(input logic [8:0] c);
		wrc(9'h000);
		wrc(c);
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdchk(input string nm, input logic [3:0] a,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		@(posedge clk_sys);
		chk("pins", 32'h2, {30'h0, serialOutOe, serialOutPin});
		rdchk("ctrl", async_rx_pkg::ADDR_CTRL, 32'h0);
		rdchk("div", async_rx_pkg::ADDR_DIV, {16'h0, async_rx_pkg::DIV_RESET});
		rdchk("unmapped", 4'h1, 32'h0);
		bus(1'b1, async_rx_pkg::ADDR_DIV, 32'h0);
		gpioOutEn <= 1'b0;
		wrc(9'h001);
		@(posedge clk_sys);
		chk("pins", 32'h3, {30'h0, serialOutOe, serialOutPin});
		$display("reset test done");
		foreach (rows[i]) begin
			wrc(9'h000);
			invert <= rows[i].v;
			wrc(rows[i].c);
			i_tx.send(rows[i].d, rows[i].c[3], rows[i].s, 16);
			rdchk("status", async_rx_pkg::ADDR_STATUS, rows[i].st);
			chk("irq", {31'h0, rows[i].st[5]}, {31'h0, rxIrq});
			rdchk("data", async_rx_pkg::ADDR_DATA, {23'h0, rows[i].d});
			$display("row %0d done", i);
		end
		fresh(9'h003);
		i_tx.send(9'h000, 1'b0, 1'b1, 4);
		rdchk("false start", async_rx_pkg::ADDR_STATUS, 32'h10);
		fresh(9'h003);
		i_tx.send(9'h011, 1'b0, 1'b1, 16);
		i_tx.send(9'h022, 1'b0, 1'b0, 16);
		i_tx.send(9'h033, 1'b0, 1'b1, 16);
		i_tx.send(9'h044, 1'b0, 1'b1, 16);
		rdchk("overrun", async_rx_pkg::ADDR_STATUS, 32'h15);
		rdchk("oldest", async_rx_pkg::ADDR_DATA, 32'h11);
		rdchk("next framing_error", async_rx_pkg::ADDR_STATUS, 32'h17);
		wrc(9'h001);
		rdchk("rx off", async_rx_pkg::ADDR_STATUS, 32'h12);
		wrc(9'h003);
		rdchk("rx on", async_rx_pkg::ADDR_STATUS, 32'h13);
		rdchk("kept", async_rx_pkg::ADDR_DATA, 32'h22);
		fork
			i_tx.send(9'h055, 1'b0, 1'b1, 16);
			begin
				repeat (40) @(posedge clk_sys);
				rdchk("busy", async_rx_pkg::ADDR_STATUS, 32'h0);
			end
		join
		rdchk("resume", async_rx_pkg::ADDR_DATA, 32'h55);
		i_tx.send(9'h066, 1'b0, 1'b0, 16);
		rdchk("framing_error", async_rx_pkg::ADDR_STATUS, 32'h13);
		wrc(9'h000);
		rdchk("port off", async_rx_pkg::ADDR_STATUS, 32'h10);
		$display("overrun test done");
		fresh(9'h01b);
		i_tx.send(9'h0aa, 1'b1, 1'b1, 16);
		i_tx.send(9'h1c4, 1'b1, 1'b1, 16);
		rdchk("addr", async_rx_pkg::ADDR_STATUS, 32'h19);
		rdchk("addr data", async_rx_pkg::ADDR_DATA, 32'h1c4);
		wrc(9'h00b);
		i_tx.send(9'h033, 1'b1, 1'b1, 16);
		rdchk("msg data", async_rx_pkg::ADDR_DATA, 32'h33);
		fresh(9'h007);
		i_tx.send(9'h05a, 1'b0, 1'b1, 16);
		bus(1'b0, async_rx_pkg::ADDR_STATUS, 32'h0);
		chk("sync off", 32'h0, q & 32'h1);
		$display("mode test done");
		print_verdict();
	end
endmodule
